// ---- verilog/wdiu_top.sv ----
// Watchdog and interrupt controller facing the processor core
//
// Contract
// - Watchdog runs from its own oscillator
// - Power control bit 7 gates watchdog counting
// - Setting picks chip reset or interrupt
// - Timeout clears status timeout flag bit 4
// - Base periods 3.5, 15, 60, 250 ms
// - Prescaler assign lengthens watchdog period
// - Ratio 1:1-1:128 reset, 1:2-1:256 interrupt
// - Clear instruction clears counters, sets flag
// - Interrupt mode timeout sets flag bit 6
// - Seven hardware interrupt sources
// - Global enable gates; enable/disable instructions
// - Software interrupt vectors 0x001, clears enable
// - Return sets global enable, resumes
// - Flags sticky until firmware writes 0
// - Flag reads set only when enabled
// - Enabled flag with enable vectors 0x008
// - Timer 0 overflow sets its flag
// - Timer 1 and 2 underflow set flags
// - Enabled input pin change sets port flag
// - External select disables pin 0 change
// - Selected edge on pin 0 sets flag
// - Comparator mismatch sets flag; read updates copy
// - Comparator flag only while comparator enabled
`timescale 1ns/1ps
`default_nettype none

module wdiu_top #(
	parameter int unsigned OSC_HZ = wdiu_pkg::WDT_OSC_HZ // Watchdog oscillator rate
) (
	input  wire logic                    sys_clk,            // System clock, 50 MHz
	input  wire logic                    reset_n,            // Synchronous reset, active low
	input  wire logic                    watchdog_osc_pin,   // Free-running watchdog oscillator
	input  wire wdiu_pkg::wdiu_wdt_cfg_s wdt_cfg,            // Watchdog settings
	input  wire logic [7:0]              power_control_reg,  // Power control register
	input  wire wdiu_pkg::wdiu_instr_s   instr,              // Instruction strobes
	input  wire logic                    timer0_overflow,    // Timer 0 overflow pulse
	input  wire logic                    timer1_underflow,   // Timer 1 underflow pulse
	input  wire logic                    timer2_underflow,   // Timer 2 underflow pulse
	input  wire logic [7:0]              port_b_pin,         // Port B pin levels
	input  wire logic [7:0]              port_b_is_input,    // Port B input direction
	input  wire logic [7:0]              pin_wake_enable,    // Per-pin change enables
	input  wire logic                    ext_irq_select,     // Pin 0 used as external irq
	input  wire logic                    ext_edge_select,    // 1: rising, 0: falling
	input  wire logic                    comparator_out,     // Raw comparator output
	input  wire logic                    comparator_enable,  // Comparator enable bit
	input  wire logic                    halted,             // Core in halt state
	input  wire logic [7:0]              irq_enable_reg,     // Interrupt enable register
	input  wire logic                    irq_flag_wr,        // Flag register write strobe
	input  wire logic [7:0]              irq_flag_wr_data,   // Flag register write data
	output logic      [7:0]              irq_flag_reg,       // Flags as read by firmware
	output logic                         global_irq_enable,  // Global enable state
	output logic                         vector_valid,       // Redirect fetch pulse
	output logic      [10:0]             vector_addr,        // Redirect address
	output logic                         chip_reset_req,     // Watchdog chip reset pulse
	output logic                         timeout_flag_n,     // Status timeout flag
	output logic                         comparator_copy     // Registered comparator state
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic       osc_rise;    // One pulse per oscillator cycle
	logic [7:0] pb_level;    // Settled port B levels
	logic [7:0] pb_rise;     // Port B rising edges
	logic [7:0] pb_fall;     // Port B falling edges
	logic       cmp_level;   // Settled comparator output

	// Oscillator edge becomes a tick in the system domain
	wdiu_pin_sync #(.W(1)) u_osc_sync (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.pin_in  (watchdog_osc_pin),
		.level   (),
		.rise    (osc_rise),
		.fall    ()
	);

	// Port B pins for change and external edge detection
	wdiu_pin_sync #(.W(8)) u_pb_sync (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.pin_in  (port_b_pin),
		.level   (pb_level),
		.rise    (pb_rise),
		.fall    (pb_fall)
	);

	// Comparator output is asynchronous to the core
	wdiu_pin_sync #(.W(1)) u_cmp_sync (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.pin_in  (comparator_out),
		.level   (cmp_level),
		.rise    (),
		.fall    ()
	);

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	logic wdt_timeout; // Timeout pulse
	logic wdt_irq;     // Timeout in interrupt mode

	// Counter with prescaler; run bit from power control
	wdiu_watchdog #(.OSC_HZ(OSC_HZ)) u_watchdog (
		.sys_clk        (sys_clk),
		.reset_n        (reset_n),
		.osc_tick       (osc_rise),
		.cfg            (wdt_cfg),
		.run_enable     (power_control_reg[wdiu_pkg::POWER_CONTROL_REG_RUN]),
		.clear_instr    (instr.watchdog_clear_instr),
		.timeout        (wdt_timeout),
		.chip_reset_req (chip_reset_req),
		.irq_event      (wdt_irq),
		.timeout_flag_n (timeout_flag_n)
	);

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	logic [7:0] pb_change;  // Qualified port change per pin
	logic       cmp_active; // Comparator running
	logic       ext_edge;   // Selected edge on pin 0
	logic [7:0] set_vec;    // Events this cycle

	// Pin 0 change is masked while it serves as external interrupt
	always_comb begin
		pb_change    = (pb_rise | pb_fall) & port_b_is_input & pin_wake_enable;
		pb_change[0] = pb_change[0] & !ext_irq_select;
	end

	// Comparator is off when disabled or halted
	assign cmp_active = comparator_enable & !halted;

	// External edge chosen by edge select
	assign ext_edge = ext_irq_select & (ext_edge_select ? pb_rise[0] : pb_fall[0]);

	// Gather the seven hardware sources
	always_comb begin
		set_vec                       = 8'h00;
		set_vec[wdiu_pkg::BIT_TIMER0] = timer0_overflow;
		set_vec[wdiu_pkg::BIT_TIMER1] = timer1_underflow;
		set_vec[wdiu_pkg::BIT_TIMER2] = timer2_underflow;
		set_vec[wdiu_pkg::BIT_WDT]    = wdt_irq;
		set_vec[wdiu_pkg::BIT_PORT]   = |pb_change;
		set_vec[wdiu_pkg::BIT_EXT]    = ext_edge;
		set_vec[wdiu_pkg::BIT_CMP]    = cmp_active & (cmp_level != comparator_copy);
	end

	// Registered comparator copy, refreshed on control register read
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			comparator_copy <= 1'b0;
		end else if (instr.osc_ctrl_read) begin
			comparator_copy <= cmp_level;
		end
	end

	// ----------------------------------------------------------------
	// Flag register
	// ----------------------------------------------------------------
	logic [7:0] flags;      // Raw sticky flags
	logic [7:0] next_flags; // Flags after write and events

	// Write lands first, hardware set overrides it
	always_comb begin
		next_flags = irq_flag_wr ? irq_flag_wr_data : flags;
		next_flags = (next_flags | set_vec) & wdiu_pkg::FLAG_USED;
	end

	// Sticky flag storage
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			flags <= wdiu_pkg::FLAG_RESET;
		end else begin
			flags <= next_flags;
		end
	end

	// Firmware sees only enabled flags
	assign irq_flag_reg = flags & irq_enable_reg;

	// ----------------------------------------------------------------
	// Global enable and vectoring
	// ----------------------------------------------------------------
	logic hw_take; // Hardware interrupt taken now
	logic sw_take; // Software interrupt taken now

	// Pending enabled flag waits until global enable is set
	assign hw_take = global_irq_enable & (|irq_flag_reg) & !instr.software_irq_instr;
	assign sw_take = instr.software_irq_instr;

	// Global enable: vectoring clears it, instructions steer it
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			global_irq_enable <= 1'b0;
		end else if (sw_take || hw_take) begin
			global_irq_enable <= 1'b0;
		end else if (instr.enable_irq_instr || instr.return_from_irq_instr) begin
			global_irq_enable <= 1'b1;
		end else if (instr.disable_irq_instr) begin
			global_irq_enable <= 1'b0;
		end
	end

	// Fetch redirect, software entry wins over hardware
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			vector_valid <= 1'b0;
			vector_addr  <= wdiu_pkg::VEC_RESET;
		end else begin
			vector_valid <= sw_take | hw_take;
			if (sw_take) begin
				vector_addr <= wdiu_pkg::SWI_VEC;
			end else if (hw_take) begin
				vector_addr <= wdiu_pkg::HW_VEC;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_hw_request;
		global_irq_enable && (|irq_flag_reg) && !instr.software_irq_instr;
	endsequence

	sequence s_hw_vector;
		vector_valid && vector_addr == wdiu_pkg::HW_VEC && !global_irq_enable;
	endsequence

	property p_hw_vector;
		@(posedge sys_clk) disable iff (!reset_n) s_hw_request |=> s_hw_vector;
	endproperty
	a_hw_vector: assert property (p_hw_vector)
		else $error("hardware request not vectored to 0x008");

	property p_sw_vector;
		@(posedge sys_clk) disable iff (!reset_n) instr.software_irq_instr |=>
			vector_valid && vector_addr == wdiu_pkg::SWI_VEC && !global_irq_enable;
	endproperty
	a_sw_vector: assert property (p_sw_vector)
		else $error("software interrupt not vectored to 0x001");

	property p_no_vector_without_enable;
		@(posedge sys_clk) disable iff (!reset_n)
			!global_irq_enable && !instr.software_irq_instr |=> !vector_valid;
	endproperty
	a_no_vector_without_enable: assert property (p_no_vector_without_enable)
		else $error("vector taken with global enable low");

	property p_return_sets_enable;
		@(posedge sys_clk) disable iff (!reset_n)
			instr.return_from_irq_instr && !instr.software_irq_instr && !(|irq_flag_reg)
			|=> global_irq_enable;
	endproperty
	a_return_sets_enable: assert property (p_return_sets_enable)
		else $error("return did not set global enable");

	property p_flag_sticky;
		@(posedge sys_clk) disable iff (!reset_n)
			flags[wdiu_pkg::BIT_TIMER0] && !irq_flag_wr |=> flags[wdiu_pkg::BIT_TIMER0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag dropped without firmware write");

	property p_set_beats_clear;
		@(posedge sys_clk) disable iff (!reset_n)
			timer1_underflow && irq_flag_wr |=> flags[wdiu_pkg::BIT_TIMER1];
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear)
		else $error("event lost to same-cycle clear");

	property p_read_masked;
		@(posedge sys_clk) disable iff (!reset_n)
			!irq_enable_reg[wdiu_pkg::BIT_WDT] |-> !irq_flag_reg[wdiu_pkg::BIT_WDT];
	endproperty
	a_read_masked: assert property (p_read_masked)
		else $error("disabled flag read as set");

	property p_pin0_masked;
		@(posedge sys_clk) disable iff (!reset_n)
			ext_irq_select |-> !pb_change[0];
	endproperty
	a_pin0_masked: assert property (p_pin0_masked)
		else $error("pin 0 change seen with external select");

	property p_cmp_quiet;
		@(posedge sys_clk) disable iff (!reset_n)
			!cmp_active && !flags[wdiu_pkg::BIT_CMP] && !irq_flag_wr
			|=> !flags[wdiu_pkg::BIT_CMP];
	endproperty
	a_cmp_quiet: assert property (p_cmp_quiet)
		else $error("comparator flag while comparator off");

	property p_pending_taken;
		@(posedge sys_clk) disable iff (!reset_n)
			!global_irq_enable ##1 (global_irq_enable && (|irq_flag_reg)
			&& !instr.software_irq_instr) |=> vector_valid;
	endproperty
	a_pending_taken: assert property (p_pending_taken)
		else $error("pending flag not taken after enable");

	property p_wdt_flag;
		@(posedge sys_clk) disable iff (!reset_n) wdt_irq |=> flags[wdiu_pkg::BIT_WDT];
	endproperty
	a_wdt_flag: assert property (p_wdt_flag)
		else $error("watchdog flag not set on timeout");

	property p_timeout_flag;
		@(posedge sys_clk) disable iff (!reset_n) wdt_timeout |-> !timeout_flag_n;
	endproperty
	a_timeout_flag: assert property (p_timeout_flag)
		else $error("timeout pulse without timeout flag low");

endmodule // wdiu_top

`default_nettype wire

// ---- inc/wdiu_pkg.sv ----
// Shared constants and carrier types for the watchdog and interrupt unit
package wdiu_pkg;

	// ----------------------------------------------------------------
	// Clock and watchdog timing
	// ----------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ     = 50_000_000; // System clock rate
	localparam int unsigned WDT_OSC_HZ     = 32_000;     // Watchdog oscillator rate
	localparam int unsigned WDT_CNT_W      = 16;         // Base counter width
	localparam int unsigned WDT_PRE_W      = 9;          // Prescaler counter width
	localparam int unsigned WDT_PERIOD0_US = 3_500;      // Base period 3.5 ms
	localparam int unsigned WDT_PERIOD1_US = 15_000;     // Base period 15 ms
	localparam int unsigned WDT_PERIOD2_US = 60_000;     // Base period 60 ms
	localparam int unsigned WDT_PERIOD3_US = 250_000;    // Base period 250 ms
	localparam int unsigned US_PER_S       = 1_000_000;  // Microseconds per second

	// ----------------------------------------------------------------
	// Interrupt flag and enable bit positions
	// ----------------------------------------------------------------
	localparam int unsigned IRQ_W       = 8; // Flag and enable register width
	localparam int unsigned BIT_TIMER0  = 0; // Timer 0 overflow
	localparam int unsigned BIT_PORT    = 1; // Port B input change
	localparam int unsigned BIT_EXT     = 2; // External pin edge
	localparam int unsigned BIT_TIMER1  = 3; // Timer 1 underflow
	localparam int unsigned BIT_TIMER2  = 4; // Timer 2 underflow
	localparam int unsigned BIT_CMP     = 5; // Comparator output change
	localparam int unsigned BIT_WDT     = 6; // Watchdog timeout
	localparam int unsigned POWER_CONTROL_REG_RUN    = 7; // Run-control bit in power control
	localparam int unsigned STATUS_TO   = 4; // Timeout flag bit in status
	localparam logic [7:0]  FLAG_USED   = 8'h7F; // Implemented flag bits
	localparam logic [7:0]  FLAG_RESET  = 8'h00; // Flags after reset

	// ----------------------------------------------------------------
	// Vector addresses
	// ----------------------------------------------------------------
	localparam int unsigned VEC_W     = 11;        // Fetch address width
	localparam logic [10:0] SWI_VEC   = 11'h001;   // Software interrupt entry
	localparam logic [10:0] HW_VEC    = 11'h008;   // Hardware interrupt entry
	localparam logic [10:0] VEC_RESET = 11'h000;   // Idle vector value

	// Instruction strobes from the processor core, one cycle each
	typedef struct packed {
		logic enable_irq_instr;      // Sets global enable
		logic disable_irq_instr;     // Clears global enable
		logic software_irq_instr;    // Software interrupt
		logic return_from_irq_instr; // Return, sets global enable
		logic watchdog_clear_instr;  // Clears watchdog and prescaler
		logic osc_ctrl_read;         // Read of oscillator control reg
	} wdiu_instr_s;

	// Watchdog configuration settings and control bits
	typedef struct packed {
		logic       cfg_enable;             // Configuration enable
		logic       cfg_irq_mode;           // 1: interrupt, 0: chip reset
		logic [1:0] cfg_period_select;      // Base period choice
		logic       prescaler_to_watchdog;  // Prescaler assigned to watchdog
		logic [2:0] prescaler_ratio_select; // Division ratio choice
	} wdiu_wdt_cfg_s;

endpackage

// ---- verilog/wdiu_pin_sync.sv ----
// Two-flop synchroniser with change and edge detection
`timescale 1ns/1ps
`default_nettype none

module wdiu_pin_sync #(
	parameter int unsigned W = 1 // Number of synchronised bits
) (
	input  wire logic         sys_clk,  // System clock
	input  wire logic         reset_n,  // Synchronous reset, active low
	input  wire logic [W-1:0] pin_in,   // Asynchronous inputs
	output logic      [W-1:0] level,    // Synchronised level
	output logic      [W-1:0] rise,     // Rising edge pulse
	output logic      [W-1:0] fall      // Falling edge pulse
);

	logic [W-1:0] meta;  // First stage, read only by the second
	logic [W-1:0] prev;  // Level one cycle earlier

	// Synchroniser chain and history
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			meta  <= '0;
			level <= '0;
			prev  <= '0;
		end else begin
			meta  <= pin_in;
			level <= meta;
			prev  <= level;
		end
	end

	// Edges seen on the settled level only
	assign rise = level & ~prev;
	assign fall = ~level & prev;

endmodule // wdiu_pin_sync

`default_nettype wire

// ---- verilog/wdiu_watchdog.sv ----
// Watchdog counter with optional prescaler and timeout action
`timescale 1ns/1ps
`default_nettype none

module wdiu_watchdog #(
	parameter int unsigned OSC_HZ = wdiu_pkg::WDT_OSC_HZ // Oscillator rate
) (
	input  wire logic                   sys_clk,         // System clock
	input  wire logic                   reset_n,         // Sync reset, active low
	input  wire logic                   osc_tick,        // One tick per oscillator cycle
	input  wire wdiu_pkg::wdiu_wdt_cfg_s cfg,            // Configuration
	input  wire logic                   run_enable,      // Run-control bit
	input  wire logic                   clear_instr,     // Watchdog clear strobe
	output logic                        timeout,         // Timeout pulse
	output logic                        chip_reset_req,  // Reset request pulse
	output logic                        irq_event,       // Interrupt event pulse
	output logic                        timeout_flag_n   // Timeout flag, low after timeout
);

	logic [wdiu_pkg::WDT_CNT_W-1:0] count;  // Base period counter
	logic [wdiu_pkg::WDT_PRE_W-1:0] pre;    // Prescaler counter
	logic                           counting; // Counting allowed
	logic                           base_hit; // Base period elapsed
	logic                           expire;   // Whole period elapsed

	// Oscillator ticks in one base period
	function automatic logic [wdiu_pkg::WDT_CNT_W-1:0] base_ticks(input logic [1:0] sel);
		longint unsigned us;
		case (sel)
			2'h0:    us = wdiu_pkg::WDT_PERIOD0_US;
			2'h1:    us = wdiu_pkg::WDT_PERIOD1_US;
			2'h2:    us = wdiu_pkg::WDT_PERIOD2_US;
			default: us = wdiu_pkg::WDT_PERIOD3_US;
		endcase
		return wdiu_pkg::WDT_CNT_W'((us * longint'(OSC_HZ)) / wdiu_pkg::US_PER_S);
	endfunction

	// Prescaler ratio, doubled in interrupt mode
	function automatic logic [wdiu_pkg::WDT_PRE_W-1:0] ratio(input logic [2:0] sel,
		input logic irq_mode);
		return wdiu_pkg::WDT_PRE_W'(9'h001 << (4'(sel) + 4'(irq_mode)));
	endfunction

	// Oscillator runs regardless of power state; config and run bit gate it
	assign counting = cfg.cfg_enable & run_enable;
	assign base_hit = counting & osc_tick
		& (count == base_ticks(cfg.cfg_period_select) - 1'b1);
	assign expire   = base_hit & (!cfg.prescaler_to_watchdog
		| (pre == ratio(cfg.prescaler_ratio_select, cfg.cfg_irq_mode) - 1'b1));

	// Base counter and prescaler
	always_ff @(posedge sys_clk) begin
		if (!reset_n || clear_instr) begin
			count <= '0;
			pre   <= '0;
		end else if (counting && osc_tick) begin
			count <= base_hit ? '0 : count + 1'b1;
			if (base_hit && cfg.prescaler_to_watchdog) begin
				pre <= expire ? '0 : pre + 1'b1;
			end
		end
	end

	// Timeout action pulses
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			timeout        <= 1'b0;
			chip_reset_req <= 1'b0;
			irq_event      <= 1'b0;
		end else begin
			timeout        <= expire;
			chip_reset_req <= expire & !cfg.cfg_irq_mode;
			irq_event      <= expire & cfg.cfg_irq_mode;
		end
	end

	// Timeout flag, cleared by timeout and set by the clear strobe
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			timeout_flag_n <= 1'b1;
		end else if (expire) begin
			timeout_flag_n <= 1'b0;
		end else if (clear_instr) begin
			timeout_flag_n <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_flag_low_on_timeout;
		@(posedge sys_clk) disable iff (!reset_n) expire |=> !timeout_flag_n;
	endproperty
	a_flag_low_on_timeout: assert property (p_flag_low_on_timeout)
		else $error("timeout flag not cleared by timeout");

	property p_clear_restarts;
		@(posedge sys_clk) disable iff (!reset_n)
			clear_instr && !expire |=> timeout_flag_n && count == '0 && pre == '0;
	endproperty
	a_clear_restarts: assert property (p_clear_restarts)
		else $error("clear did not restart watchdog");

	property p_mode_split;
		@(posedge sys_clk) disable iff (!reset_n)
			expire |=> (chip_reset_req != irq_event) && (irq_event == $past(cfg.cfg_irq_mode));
	endproperty
	a_mode_split: assert property (p_mode_split)
		else $error("timeout action does not follow mode");

	property p_stopped_holds;
		@(posedge sys_clk) disable iff (!reset_n)
			!counting && !clear_instr |=> $stable(count);
	endproperty
	a_stopped_holds: assert property (p_stopped_holds)
		else $error("watchdog counted while stopped");

endmodule // wdiu_watchdog

`default_nettype wire

// ---- verification/wdiu_core_model.sv ----
// Processor core model issuing one-cycle instruction strobes
`timescale 1ns/1ps
`default_nettype none

module wdiu_core_model (
	input  wire logic [5:0]        req,   // Requested strobes, MSB first
	input  wire logic              sys_clk, // System clock
	output var wdiu_pkg::wdiu_instr_s instr // Strobes to the unit
);
	// Launch on the falling edge so the unit samples a settled strobe
	always @(negedge sys_clk) instr <= wdiu_pkg::wdiu_instr_s'(req);
endmodule // wdiu_core_model

`default_nettype wire

// ---- verification/tb_watchdog_and_interrupt_unit.sv ----
// Self-checking bench for the watchdog and interrupt unit
`timescale 1ns/1ps
`default_nettype none

module tb_watchdog_and_interrupt_unit;
	logic sys_clk = 0, reset_n = 0, watchdog_osc_pin = 0, timer0_overflow = 0;
	logic timer1_underflow = 0, timer2_underflow = 0, ext_irq_select = 0, comparator_out = 0;
	logic ext_edge_select = 1, comparator_enable = 1, halted = 0;
	logic irq_flag_wr = 0, global_irq_enable, vector_valid, chip_reset_req, timeout_flag_n;
	logic comparator_copy;
	logic [7:0] power_control_reg = 8'h80, irq_enable_reg = 8'h00, irq_flag_wr_data = 8'h00;
	logic [7:0] port_b_pin = 8'h00, pin_wake_enable = 8'hFF, irq_flag_reg;
	logic [10:0] vector_addr;
	logic [5:0] req = 6'h00;
	wdiu_pkg::wdiu_wdt_cfg_s wdt_cfg = '0;
	wdiu_pkg::wdiu_instr_s instr;
	logic [10:0] exp_q[$]; // Expected vector addresses
	int fails = 0, n_checks = 0, n = 0;
	wdiu_top #(.OSC_HZ(1000)) uut (.sys_clk, .reset_n, .watchdog_osc_pin, .wdt_cfg,
		.power_control_reg, .instr, .timer0_overflow, .timer1_underflow, .timer2_underflow,
		.port_b_pin, .port_b_is_input(8'hFF), .pin_wake_enable, .ext_irq_select,
		.ext_edge_select, .comparator_out, .comparator_enable, .halted,
		.irq_enable_reg, .irq_flag_wr, .irq_flag_wr_data, .irq_flag_reg, .global_irq_enable,
		.vector_valid, .vector_addr, .chip_reset_req, .timeout_flag_n, .comparator_copy);
	wdiu_core_model core (.req, .sys_clk, .instr);
	initial forever #10 sys_clk = ~sys_clk;
	initial forever #100 watchdog_osc_pin = ~watchdog_osc_pin;
	// Compare and count
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int n); repeat (n) @(negedge sys_clk); endtask
	// One instruction strobe through the core model
	task automatic issue(input logic [5:0] c);
		@(posedge sys_clk) req <= c;
		@(posedge sys_clk) req <= 6'h00;
		cyc(1);
	endtask
	task automatic wr_flags(input logic [7:0] d); irq_flag_wr = 1; irq_flag_wr_data = d; cyc(1); irq_flag_wr = 0; endtask
	// Each vector pops the oldest expected address
	always @(negedge sys_clk) begin
		if (vector_valid === 1'b1) begin
			check(vector_addr, exp_q.size() ? exp_q.pop_front() : 11'h7FF);
		end
	end
	initial begin #200000 fails++; finish_test(); end
	initial begin
		void'($urandom(32'hf19c));
		cyc(5); reset_n = 1; cyc(1);
		exp_q.push_back(11'h001); issue(6'h08); cyc(2);
		check(global_irq_enable, 0);
		$display("software vector done");
		irq_enable_reg = 8'h01; issue(6'h20); cyc(1); check(global_irq_enable, 1);
		exp_q.push_back(11'h008); timer0_overflow = 1; cyc(1); timer0_overflow = 0; cyc(4);
		check(irq_flag_reg, 8'h01);
		check(global_irq_enable, 0);
		irq_enable_reg = 8'h09; irq_flag_wr = 1; irq_flag_wr_data = 8'h00; timer1_underflow = 1; cyc(1);
		irq_flag_wr = 0; timer1_underflow = 0; cyc(1); check(irq_flag_reg, 8'h08);
		irq_enable_reg = 8'hFF; irq_flag_wr_data = 8'($urandom); wr_flags(irq_flag_wr_data); cyc(1);
		check(irq_flag_reg, irq_flag_wr_data & 8'h7F);
		wr_flags(8'h10); irq_enable_reg = 8'h00; cyc(1); check(irq_flag_reg, 8'h00);
		irq_enable_reg = 8'h10; exp_q.push_back(11'h008); issue(6'h20); cyc(3);
		wr_flags(8'h00); issue(6'h04); cyc(1); check(global_irq_enable, 1);
		issue(6'h10); cyc(1); check(global_irq_enable, 0);
		$display("hardware vector done");
		irq_enable_reg = 8'h26; ext_irq_select = 1; port_b_pin = 8'h01; cyc(5);
		check(irq_flag_reg, 8'h04);
		port_b_pin = 8'h03; cyc(5); check(irq_flag_reg, 8'h06);
		comparator_out = 1; cyc(5); check(irq_flag_reg, 8'h26);
		issue(6'h01); cyc(1); check(comparator_copy, 1);
		halted = 1; ext_edge_select = 0; wr_flags(8'h00);
		comparator_out = 0; port_b_pin = 8'h02; cyc(5);
		check(irq_flag_reg, 8'h04);
		halted = 0; cyc(2); check(irq_flag_reg, 8'h24);
		$display("pin sources done");
		wr_flags(8'h00); irq_enable_reg = 8'h40; wdt_cfg = '{1'b1, 1'b1, 2'd0, 1'b0, 3'd0};
		repeat (300) if (timeout_flag_n !== 1'b0) cyc(1);
		cyc(3); check(timeout_flag_n, 0);
		check(irq_flag_reg, 8'h40);
		issue(6'h02); cyc(1); check(timeout_flag_n, 1);
		wr_flags(8'h00); wdt_cfg.cfg_irq_mode = 0;
		wdt_cfg.prescaler_to_watchdog = 1; wdt_cfg.prescaler_ratio_select = 3'd1;
		issue(6'h02);
		repeat (300) if (chip_reset_req !== 1'b1) begin cyc(1); n++; end
		check(chip_reset_req, 1);
		check(n inside {[51:60]}, 1);
		cyc(3); check(irq_flag_reg, 8'h00);
		$display("watchdog done");
		check(exp_q.size(), 0);
		finish_test();
	end
endmodule // tb_watchdog_and_interrupt_unit

`default_nettype wire
